// ===== src/eivu_consts.vh
// constants for the external interrupt and vector unit
// assumes inclusion by bare name from the design files
`ifndef EIVU_CONSTS_VH
`define EIVU_CONSTS_VH
// register word indices, byte address is four times the index
`define EIVU_IDX_SENSE       8'h35
`define EIVU_IDX_MASK        8'h3b
`define EIVU_IDX_FLAGS       8'h3a
`define EIVU_IDX_PMASK_HI    8'h20
`define EIVU_IDX_PMASK_LO    8'h12
`define EIVU_IDX_PINS        8'h3f
// field positions
`define EIVU_BIT_EXT         6
`define EIVU_BIT_HI          5
`define EIVU_BIT_LO          4
`define EIVU_LIVE_MASK       8'h70
`define EIVU_SENSE_LSB       0
// sense encodings
`define EIVU_SENSE_LOW       2'b00
`define EIVU_SENSE_ANY       2'b01
`define EIVU_SENSE_FALL      2'b10
`define EIVU_SENSE_RISE      2'b11
// vector word addresses
`define EIVU_VEC_RESET       4'h0
`define EIVU_VEC_EXT         4'h1
`define EIVU_VEC_LO          4'h2
`define EIVU_VEC_HI          4'h3
`define EIVU_VEC_WDOG        4'h4
`define EIVU_VEC_FIRST_PERIPH 4'h4
// bus answers
`define EIVU_RESP_OKAY       2'b00
`define EIVU_RESP_SLVERR     2'b10
`define EIVU_RESET_BYTE      8'h00
`endif

// ===== src/eivu_sync.v
// two-flop synchroniser for a bus of asynchronous levels
// assumes one clock aclk; inputs may change at any time
`timescale 1ns/1ns
module eivu_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             aclk,
  input  wire             aresetn,
  // levels
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;
  always @(posedge aclk) begin
    if (!aresetn) begin
      stage1   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// ===== src/eivu_vec_pick.v
// priority picker: lowest numbered pending request wins
// assumes request bit n maps to vector word address n+1
`timescale 1ns/1ns
`include "eivu_consts.vh"
module eivu_vec_pick #(
  parameter NREQ = 15
) (
  // requests
  input  wire [NREQ-1:0] req,
  // selection
  output reg             any,
  output reg  [3:0]      addr
);
  integer i;
  always @* begin
    any  = 1'b0;
    addr = `EIVU_VEC_RESET;
    for (i = NREQ - 1; i >= 0; i = i - 1) begin
      if (req[i]) begin
        any  = 1'b1;
        addr = i[3:0] + 4'h1;
      end
    end
  end
endmodule

// ===== src/eivu_top.v
// external interrupt and vector unit with axi4-lite register slave
// assumes one clock aclk, pins asynchronous, core gives global enable and ack
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "eivu_consts.vh"
// Operation
// - all resets fetch vector address zero
// - ext pin 1, low group 2, high group 3
// - watchdog 4, timer b matches/overflow 5-7
// - remaining peripheral sources at 8 through f
// - pin activity triggers even when driven output
// - group requests on toggle of enabled pin
// - pin changes captured without clock, synchronised; here detected only from aclk samples through eivu_sync
// - sense field selects low, any, fall, rise
// - low level keeps requesting while pin low
// - ext pin events detected for wake
// - vanished wake level wakes without interrupt
// - ext pin needs mask bit6 and global
// - high group needs bit5, global, pin mask
// - low group needs bit4, global, pin mask
// - reserved mask and flag bits read zero
// - ext flag set, cleared by vector/write-one
// - group flags set, cleared by vector/write-one
// - pin masks enable pins, reset zero
module eivu_top #(
  parameter NPINS = 16,
  parameter NPER  = 12
) (
  // clock and reset
  input  wire             aclk,
  input  wire             aresetn,
  // axi4-lite write address
  input  wire [7:0]       s_axi_awaddr,
  input  wire             s_axi_awvalid,
  output reg              s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  input  wire             s_axi_wvalid,
  output reg              s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]       s_axi_bresp,
  output reg              s_axi_bvalid,
  input  wire             s_axi_bready,
  // axi4-lite read
  input  wire [7:0]       s_axi_araddr,
  input  wire             s_axi_arvalid,
  output reg              s_axi_arready,
  output reg  [31:0]      s_axi_rdata,
  output reg  [1:0]       s_axi_rresp,
  output reg              s_axi_rvalid,
  input  wire             s_axi_rready,
  // port pins, read whatever their direction
  input  wire [NPINS-1:0] pin_change_input,
  input  wire             ext_pin_irq,
  // other peripheral requests, vectors 4 to f in order
  input  wire [NPER-1:0]  periph_req,
  // core side
  input  wire             core_global_enable,
  input  wire             core_reset_fetch,
  input  wire             core_vec_ack,
  output reg              core_irq,
  output reg  [3:0]       core_vec_addr,
  output reg              core_wake
);
  // ****************************************
  // pin synchronisation
  // ****************************************
  wire [NPINS-1:0] pins_s;
  wire             ext_s;
  eivu_sync #(.WIDTH(NPINS+1)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({ext_pin_irq, pin_change_input}),
    .sync_out ({ext_s, pins_s})
  );
  reg [NPINS-1:0] pins_d;
  reg             ext_d;
  // ****************************************
  // registers
  // ****************************************
  reg [7:0] sense_reg;
  reg [7:0] gmask;
  reg [7:0] pin_mask_lo;
  reg [7:0] pin_mask_hi;
  reg       ext_pin_flag;
  reg       group_lo_flag;
  reg       group_hi_flag;
  wire [1:0] sense_select_field = sense_reg[`EIVU_SENSE_LSB+1:`EIVU_SENSE_LSB];
  wire       ext_en    = gmask[`EIVU_BIT_EXT];
  wire       hi_en     = gmask[`EIVU_BIT_HI];
  wire       lo_en     = gmask[`EIVU_BIT_LO];
  wire       level_mode = (sense_select_field == `EIVU_SENSE_LOW);
  // ****************************************
  // event detection
  // ****************************************
  wire [NPINS-1:0] toggled = pins_s ^ pins_d;
  wire [NPINS-1:0] pmask   = {pin_mask_hi, pin_mask_lo};
  wire [NPINS-1:0] qual    = toggled & pmask;
  wire lo_evt = |qual[7:0];
  wire hi_evt = |qual[NPINS-1:8];
  reg  ext_evt;
  always @* begin
    case (sense_select_field)
      `EIVU_SENSE_ANY:  ext_evt = ext_s ^ ext_d;
      `EIVU_SENSE_FALL: ext_evt = ext_d & ~ext_s;
      `EIVU_SENSE_RISE: ext_evt = ~ext_d & ext_s;
      default:          ext_evt = 1'b0;
    endcase
  end
  wire ext_level = level_mode & ~ext_s;
  // ****************************************
  // requests and vector selection
  // ****************************************
  wire ext_req = core_global_enable & ext_en & (ext_pin_flag | ext_level);
  wire lo_req  = core_global_enable & lo_en & group_lo_flag;
  wire hi_req  = core_global_enable & hi_en & group_hi_flag;
  wire [NPER+2:0] all_req = {periph_req & {NPER{core_global_enable}},
                             hi_req, lo_req, ext_req};
  wire       pick_any;
  wire [3:0] pick_addr;
  eivu_vec_pick #(.NREQ(NPER+3)) u_pick (
    .req  (all_req),
    .any  (pick_any),
    .addr (pick_addr)
  );
  // ****************************************
  // axi4-lite slave
  // ****************************************
  reg [7:0]  aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  reg        aw_held;
  reg        w_held;
  wire       do_write = aw_held & w_held & ~s_axi_bvalid;
  wire       wr_ok = w_strb[0];
  wire [7:0] wbyte = w_data[7:0];
  wire       wr_flags = do_write & wr_ok & (aw_addr == (`EIVU_IDX_FLAGS << 2));
  wire       ack_ext = core_vec_ack & (core_vec_addr == `EIVU_VEC_EXT);
  wire       ack_lo  = core_vec_ack & (core_vec_addr == `EIVU_VEC_LO);
  wire       ack_hi  = core_vec_ack & (core_vec_addr == `EIVU_VEC_HI);
  function mapped;
    input [7:0] a;
    begin
      mapped = (a == (`EIVU_IDX_SENSE << 2)) | (a == (`EIVU_IDX_MASK << 2)) |
               (a == (`EIVU_IDX_FLAGS << 2)) | (a == (`EIVU_IDX_PMASK_HI << 2)) |
               (a == (`EIVU_IDX_PMASK_LO << 2)) | (a == (`EIVU_IDX_PINS << 2));
    end
  endfunction
  reg [7:0] rd_byte;
  always @* begin
    case (s_axi_araddr)
      (`EIVU_IDX_SENSE << 2):    rd_byte = sense_reg;
      (`EIVU_IDX_MASK << 2):     rd_byte = gmask & `EIVU_LIVE_MASK;
      (`EIVU_IDX_FLAGS << 2):    rd_byte = {1'b0, ext_pin_flag, group_hi_flag,
                                            group_lo_flag, 4'h0};
      (`EIVU_IDX_PMASK_HI << 2): rd_byte = pin_mask_hi;
      (`EIVU_IDX_PMASK_LO << 2): rd_byte = pin_mask_lo;
      (`EIVU_IDX_PINS << 2):     rd_byte = {1'b0, ext_s, 6'h00};
      default:                   rd_byte = `EIVU_RESET_BYTE;
    endcase
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `EIVU_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `EIVU_RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      sense_reg     <= `EIVU_RESET_BYTE;
      gmask         <= `EIVU_RESET_BYTE;
      pin_mask_lo   <= `EIVU_RESET_BYTE;
      pin_mask_hi   <= `EIVU_RESET_BYTE;
    end else begin
      s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr) ? `EIVU_RESP_OKAY : `EIVU_RESP_SLVERR;
        if (wr_ok) begin
          case (aw_addr)
            (`EIVU_IDX_SENSE << 2):    sense_reg   <= wbyte;
            (`EIVU_IDX_MASK << 2):     gmask       <= wbyte & `EIVU_LIVE_MASK;
            (`EIVU_IDX_PMASK_HI << 2): pin_mask_hi <= wbyte;
            (`EIVU_IDX_PMASK_LO << 2): pin_mask_lo <= wbyte;
            default: ;
          endcase
        end
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_byte};
        s_axi_rresp  <= mapped(s_axi_araddr) ? `EIVU_RESP_OKAY : `EIVU_RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // ****************************************
  // flags and core outputs
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      pins_d        <= {NPINS{1'b0}};
      ext_d         <= 1'b0;
      ext_pin_flag  <= 1'b0;
      group_lo_flag <= 1'b0;
      group_hi_flag <= 1'b0;
      core_irq      <= 1'b0;
      core_vec_addr <= `EIVU_VEC_RESET;
      core_wake     <= 1'b0;
    end else begin
      pins_d <= pins_s;
      ext_d  <= ext_s;
      // set beats clear in the same cycle
      if (level_mode)
        ext_pin_flag <= 1'b0;
      else if (ext_evt)
        ext_pin_flag <= 1'b1;
      else if (ack_ext | (wr_flags & wbyte[`EIVU_BIT_EXT]))
        ext_pin_flag <= 1'b0;
      if (hi_evt)
        group_hi_flag <= 1'b1;
      else if (ack_hi | (wr_flags & wbyte[`EIVU_BIT_HI]))
        group_hi_flag <= 1'b0;
      if (lo_evt)
        group_lo_flag <= 1'b1;
      else if (ack_lo | (wr_flags & wbyte[`EIVU_BIT_LO]))
        group_lo_flag <= 1'b0;
      // wake on any enabled pin event, held while an enabled ext pin stays low in low-level mode, even with no interrupt taken
      core_wake <= (ext_en & (ext_evt | ext_level)) |
                   (lo_en & lo_evt) | (hi_en & hi_evt);
      if (core_reset_fetch) begin
        core_irq      <= 1'b0;
        core_vec_addr <= `EIVU_VEC_RESET;
      end else if (core_vec_ack) begin
        core_irq <= 1'b0;
      end else begin
        core_irq      <= pick_any;
        core_vec_addr <= pick_addr;
      end
    end
  end
endmodule

// ===== sim/eivu_core_model.sv
// core stand-in: takes presented vectors, promptly or after a delay
// assumes the unit drops core_irq for one cycle after each ack
`timescale 1ns/1ns
module eivu_core_model (
  // clock and reset
  input  logic       aclk,
  input  logic       aresetn,
  // unit side
  input  logic       core_irq,
  input  logic [3:0] core_vec_addr,
  output logic       core_vec_ack,
  // bench control
  input  logic       serve,
  input  logic [3:0] delay,
  output logic [3:0] taken
);
  logic [3:0] wait_cnt;
  always @(posedge aclk) begin
    if (!aresetn) begin
      core_vec_ack <= 1'b0;
      wait_cnt     <= 4'h0;
      taken        <= 4'h0;
    end else if (core_vec_ack) begin
      core_vec_ack <= 1'b0;
    end else if (serve && core_irq) begin
      wait_cnt <= (wait_cnt == delay) ? 4'h0 : wait_cnt + 4'h1;
      if (wait_cnt == delay) begin
        core_vec_ack <= 1'b1;
        taken        <= core_vec_addr;
      end
    end else begin
      wait_cnt <= 4'h0;
    end
  end
endmodule

// ===== sim/eivu_checker.sv
// timing relations at the ports of eivu_top
// assumes one clock aclk and synchronous active-low aresetn
`timescale 1ns/1ns
module eivu_checker #(
  parameter NPER = 12
) (
  // clock and reset
  input logic            aclk,
  input logic            aresetn,
  // register bus
  input logic            s_axi_awready,
  input logic            s_axi_wready,
  input logic            s_axi_bvalid,
  input logic            s_axi_arready,
  input logic            s_axi_rvalid,
  input logic [31:0]     s_axi_rdata,
  // core side
  input logic [NPER-1:0] periph_req,
  input logic            core_global_enable,
  input logic            core_reset_fetch,
  input logic            core_vec_ack,
  input logic            core_irq,
  input logic [3:0]      core_vec_addr
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_fetch; core_reset_fetch ##1 core_reset_fetch; endsequence
  sequence s_wr_take; s_axi_awready && s_axi_wready; endsequence
  sequence s_wdog; (core_global_enable && periph_req[0] && !core_vec_ack
    && !core_reset_fetch) [*3]; endsequence
  property p_reset_vec; s_fetch |-> core_vec_addr == 4'h0; endproperty
  property p_wdog_first; s_wdog |-> core_irq && core_vec_addr != 4'h0
    && core_vec_addr <= 4'h4; endproperty
  property p_no_global; !core_global_enable [*3] |-> !core_irq; endproperty
  property p_ack_drop; core_vec_ack |=> !core_irq; endproperty
  property p_rd_lat; s_axi_arready |=> s_axi_rvalid; endproperty
  property p_wr_lat; s_wr_take |-> ##[1:3] s_axi_bvalid; endproperty
  property p_rd_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  property p_aw_pulse; s_axi_awready |=> !s_axi_awready; endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("reset fetch not at zero");
  a_wdog_first: assert property (p_wdog_first) else $error("watchdog order wrong");
  a_no_global: assert property (p_no_global) else $error("request without global");
  a_ack_drop: assert property (p_ack_drop) else $error("request held after ack");
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
  a_aw_pulse: assert property (p_aw_pulse) else $error("awready not a pulse");
endmodule
bind eivu_top eivu_checker #(.NPER(NPER)) u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
  .periph_req(periph_req), .core_global_enable(core_global_enable),
  .core_reset_fetch(core_reset_fetch), .core_vec_ack(core_vec_ack),
  .core_irq(core_irq), .core_vec_addr(core_vec_addr));

// ===== sim/testbench.sv
// self-checking bench for eivu_top: registers, vectors, pin events
// assumes eivu_core_model as the core and the bound checker
`timescale 1ns/1ns
module testbench;
  typedef struct packed {logic [7:0] a; logic [7:0] wd; logic [7:0] ed; logic [1:0] er;} eivu_row_t;
  eivu_row_t rows [5] = '{'{8'hd4, 8'hff, 8'hff, 2'h0}, '{8'hec, 8'hff, 8'h70, 2'h0},
    '{8'h80, 8'ha5, 8'ha5, 2'h0}, '{8'h48, 8'h5a, 8'h5a, 2'h0}, '{8'h04, 8'h33, 8'h00, 2'h2}};
  logic [1:0]  ms [6] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
  logic        lv [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
  logic [7:0]  ef [6] = '{8'h40, 8'h40, 8'h40, 8'h00, 8'h40, 8'h00};
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic        rready = 0, ext = 1, glob = 0, rfetch = 0, serve = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic [15:0] pins = 0;
  logic [11:0] periph = 0;
  logic [3:0]  delay = 0;
  wire         awready, wready, bvalid, arready, rvalid, irq, ack, wake;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire [3:0]   vaddr, taken;
  int          err_count = 0, total_checks = 0, cycles = 0, n;
  eivu_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pin_change_input(pins), .ext_pin_irq(ext), .periph_req(periph), .core_global_enable(glob),
    .core_reset_fetch(rfetch), .core_vec_ack(ack), .core_irq(irq), .core_vec_addr(vaddr),
    .core_wake(wake));
  eivu_core_model core (.aclk(aclk), .aresetn(aresetn), .core_irq(irq), .core_vec_addr(vaddr),
    .core_vec_ack(ack), .serve(serve), .delay(delay), .taken(taken));
  initial forever #20 aclk = ~aclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, {24'h0, ed});
    chk(rresp, er);
  endtask
  task automatic wait_irq(input logic lvl);
    n = 0;
    while (irq !== lvl && n < 50) begin
      @(posedge aclk);
      n++;
    end
    if (n == 50) err_count++;
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      conclude();
    end
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      rd(rows[i].a, 8'h00, rows[i].er);
      wr(rows[i].a, rows[i].wd, rows[i].er);
      rd(rows[i].a, rows[i].ed, rows[i].er);
    end
    wr(8'hec, 8'h00, 2'h0);
    glob <= 1'b1;
    for (int i = 0; i < 13; i++) begin
      periph <= (i == 12) ? 12'hfff : 12'h001 << i;
      repeat (3) @(posedge aclk);
      chk(vaddr, (i == 12) ? 4 : i + 4);
    end
    rfetch <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(vaddr, 4'h0);
    rfetch <= 1'b0;
    periph <= 12'h000;
    wr(8'h48, 8'h01, 2'h0);
    wr(8'hec, 8'h10, 2'h0);
    pins[0] <= 1'b1;
    wait_irq(1'b1);
    chk(vaddr, 4'h2);
    rd(8'he8, 8'h10, 2'h0);
    serve <= 1'b1;
    wait_irq(1'b0);
    chk(taken, 4'h2);
    serve <= 1'b0;
    rd(8'he8, 8'h00, 2'h0);
    pins[1] <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(8'he8, 8'h00, 2'h0);
    wr(8'h80, 8'h80, 2'h0);
    wr(8'hec, 8'h20, 2'h0);
    pins[15] <= 1'b1;
    wait_irq(1'b1);
    chk(vaddr, 4'h3);
    wr(8'he8, 8'h20, 2'h0);
    rd(8'he8, 8'h00, 2'h0);
    glob <= 1'b0;
    wr(8'hec, 8'h30, 2'h0);
    pins[0] <= 1'b0;
    pins[15] <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(8'he8, 8'h30, 2'h0);
    chk(irq, 1'b0);
    glob <= 1'b1;
    wait_irq(1'b1);
    chk(vaddr, 4'h2);
    delay <= 4'h3;
    serve <= 1'b1;
    n = 0;
    while (taken !== 4'h3 && n < 50) begin
      @(posedge aclk);
      n++;
    end
    chk(taken, 4'h3);
    serve <= 1'b0;
    glob <= 1'b0;
    wr(8'hec, 8'h40, 2'h0);
    foreach (ms[i]) begin
      ext <= lv[i];
      wr(8'hd4, {6'h00, ms[i]}, 2'h0);
      repeat (4) @(posedge aclk);
      wr(8'he8, 8'h40, 2'h0);
      ext <= ~lv[i];
      repeat (4) @(posedge aclk);
      rd(8'he8, ef[i], 2'h0);
    end
    wr(8'hd4, 8'h00, 2'h0);
    glob <= 1'b1;
    ext <= 1'b0;
    wait_irq(1'b1);
    chk(vaddr, 4'h1);
    rd(8'he8, 8'h00, 2'h0);
    chk(irq, 1'b1);
    chk(wake, 1'b1);
    ext <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(irq, 1'b0);
    chk(wake, 1'b0);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'hec, 8'h00, 2'h0);
    conclude();
  end
endmodule
